/* File: verilog/cdb_clock_brownout.sv */
`timescale 1ns/1ps
// Behaviour
// R1 - oscillator type comes from programming-time configuration, not a register
// R2 - on-chip rc oscillator nominal 6 mhz, slowable via cpu clock divider
// R3 - external clock option frees second oscillator pin as port pin
// R4 - clock output only with rc or external clock source, never crystal
// R5 - clock output enable drives output whenever oscillator runs, idle too
// R6 - clock output runs at one sixth of cpu clock
// R7 - software should clear clock output enable before idle to save power
// R8 - default 6 clocks per machine cycle; classic timing halves cpu clock
// R9 - classic halving also slows all peripheral timing
// R10 - divider zero gives oscillator rate, or half with classic timing
// R11 - divider n from 1 to 255 divides by 2 times (n+1)
// R12 - divider may be rewritten any time without stopping execution
// R13 - new divider value applied only at a divided-clock boundary; here a zero value bypasses the divider at once
// R14 - brownout resets by default; interrupt select bit gives interrupt instead
// R15 - thresholds 2.5 v or 3.8 v; detection held while supply below
// R16 - reset mode holds processor reset while detection asserted
// R17 - interrupt mode raises one event on the falling crossing only
// R18 - brownout interrupt needs global and brownout enables both set
// R19 - brownout flag set on detection, stays until software clears it
// R20 - level select 1 picks 2.5 v, 0 picks 3.8 v
// R21 - brownout disable bit turns detection off entirely
module cdb_clock_brownout (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire cdb_pkg::cdb_apb_req_s apb_req,
	output cdb_pkg::cdb_apb_rsp_s      apb_rsp,
	input  wire cdb_pkg::cdb_cfg_s     user_config_byte_one,
	input  wire logic                  osc_tick,
	input  wire logic                  osc_running,
	input  wire logic                  bo_below_low,
	input  wire logic                  bo_below_high,
	input  wire logic                  port_pin_out,
	input  wire logic                  port_pin_oe,
	output logic                       cpu_clk_en,
	output logic                       machine_cycle_en,
	output logic                       clock_output_pin,
	output logic                       second_osc_port_pin_oe,
	output logic                       second_osc_port_pin_out,
	output logic                       brownout_level_high,
	output logic                       brownout_reset,
	output logic                       brownout_irq
);

	localparam int DIV_W = 9;

	typedef struct packed {
		logic       clock_out_enable;
		logic [7:0] cpu_clock_divider;
		logic       brownout_irq_select;
		logic       brownout_disable;
		logic       global_irq_enable;
		logic       brownout_irq_enable;
		logic       brownout_flag;
		logic       bo_pending;
		logic       bo_det_d;
		logic       classic_phase;
		logic       pre_tick;
		logic [2:0] mc_cnt;
		logic       mc_en;
		logic       cpu_en;
		logic [1:0] co_cnt;
		logic       co_level;
		logic       co_pin;
		logic       pin_oe;
		logic       pin_out;
		logic       rst_out;
		logic       irq_out;
		logic       level_high;
		logic       pready;
		logic [31:0] prdata;
	} cdb_top_state_s;

	cdb_top_state_s st;
	cdb_top_state_s next_st;

	logic             bo_detect;
	logic             div_tick;
	logic [DIV_W-1:0] half_ratio;
	logic             apb_write;
	logic             apb_read;
	logic             rc_or_ext;
	logic             cpu_tick;

	// R20 level select
	assign bo_detect = !st.brownout_disable && (user_config_byte_one.brownout_level_select
		? bo_below_low : bo_below_high);

	assign half_ratio = DIV_W'(st.cpu_clock_divider) + 1'b1;

	// R11 divided clock
	cdb_ratio_div #(
		.W (DIV_W)
	) u_div (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.tick_in    (st.pre_tick),
		.half_ratio (half_ratio),
		.tick_out   (div_tick)
	);

	assign apb_write = apb_req.psel && apb_req.penable && apb_req.pwrite && !st.pready;
	assign apb_read  = apb_req.psel && apb_req.penable && !apb_req.pwrite && !st.pready;
	// R4 clock output source check
	assign rc_or_ext = (user_config_byte_one.osc_sel == cdb_pkg::CDB_OSC_RC)
		|| (user_config_byte_one.osc_sel == cdb_pkg::CDB_OSC_EXT_CLK);
	// R2 R10 oscillator ticks, divider bypassed at zero
	assign cpu_tick = (st.cpu_clock_divider == 8'h00) ? st.pre_tick : div_tick;

	always_comb begin
		next_st        = st;
		next_st.pready = 1'b0;
		next_st.cpu_en = 1'b0;
		next_st.mc_en  = 1'b0;

		// R8 classic halving of oscillator ticks
		next_st.pre_tick = 1'b0;
		if (osc_tick) begin
			if (user_config_byte_one.classic_timing_select) begin
				next_st.classic_phase = !st.classic_phase;
				next_st.pre_tick      = st.classic_phase;
			end else begin
				next_st.pre_tick = 1'b1;
			end
		end

		// R9 machine cycle and peripheral rate from cpu clock
		if (cpu_tick) begin
			next_st.cpu_en = 1'b1;
			if (st.mc_cnt == 3'(cdb_pkg::CLK_OUT_RATIO - 1)) begin
				next_st.mc_cnt = 3'h0;
				next_st.mc_en  = 1'b1;
			end else begin
				next_st.mc_cnt = st.mc_cnt + 3'h1;
			end
			// R6 one sixth: toggle every three cpu clocks
			if (st.co_cnt == 2'(cdb_pkg::CLK_OUT_RATIO / 2 - 1)) begin
				next_st.co_cnt   = 2'h0;
				next_st.co_level = !st.co_level;
			end else begin
				next_st.co_cnt = st.co_cnt + 2'h1;
			end
		end

		// R5 clock output while enabled and oscillator runs
		next_st.co_pin  = st.clock_out_enable && rc_or_ext && osc_running && st.co_level;
		// R3 pin ownership
		if (st.clock_out_enable && rc_or_ext) begin
			next_st.pin_oe  = 1'b1;
			next_st.pin_out = st.co_level && osc_running;
		end else if (user_config_byte_one.osc_sel == cdb_pkg::CDB_OSC_EXT_CLK) begin
			next_st.pin_oe  = port_pin_oe;
			next_st.pin_out = port_pin_out;
		end else begin
			next_st.pin_oe  = 1'b0;
			next_st.pin_out = 1'b0;
		end

		// R15 detector edge tracking
		next_st.bo_det_d   = bo_detect;
		next_st.level_high = !user_config_byte_one.brownout_level_select;
		// R14 R16 reset response while detected
		next_st.rst_out = bo_detect && !st.brownout_irq_select;

		// R19 flag clear by software, set wins
		if (apb_write && apb_req.paddr == cdb_pkg::PWR_STATUS_OFS
			&& apb_req.pwdata[cdb_pkg::BO_FLAG_BIT]) begin
			next_st.brownout_flag = 1'b0;
		end
		if (apb_write && apb_req.paddr == cdb_pkg::PWR_STATUS_OFS
			&& apb_req.pwdata[cdb_pkg::BO_IRQ_PEND_BIT]) begin
			next_st.bo_pending = 1'b0;
		end
		if (bo_detect) begin
			next_st.brownout_flag = 1'b1;
		end
		// R17 single event on falling crossing
		if (bo_detect && !st.bo_det_d && st.brownout_irq_select) begin
			next_st.bo_pending = 1'b1;
		end
		// R18 gate by both enables
		next_st.irq_out = st.bo_pending && st.global_irq_enable && st.brownout_irq_enable;

		// register writes
		if (apb_write) begin
			unique case (apb_req.paddr)
				cdb_pkg::CLK_CTRL_OFS: begin
					next_st.clock_out_enable = apb_req.pwdata[cdb_pkg::CLK_OUT_EN_BIT];
				end
				cdb_pkg::DIVIDER_OFS: begin
					// R12 R13 accepted any time, nonzero value applied at boundary, zero at once
					next_st.cpu_clock_divider = apb_req.pwdata[7:0];
				end
				cdb_pkg::AUX_CTRL_OFS: begin
					next_st.brownout_irq_select = apb_req.pwdata[cdb_pkg::BO_IRQ_SEL_BIT];
					// R21 disable bit
					next_st.brownout_disable = apb_req.pwdata[cdb_pkg::BO_DISABLE_BIT];
				end
				cdb_pkg::IRQ_ENABLE_OFS: begin
					next_st.global_irq_enable   = apb_req.pwdata[cdb_pkg::GLOBAL_IRQ_EN_BIT];
					next_st.brownout_irq_enable = apb_req.pwdata[cdb_pkg::BO_IRQ_EN_BIT];
				end
				default: begin
				end
			endcase
		end

		if (apb_req.psel && apb_req.penable && !st.pready) begin
			next_st.pready = 1'b1;
		end
		next_st.prdata = 32'h0;
		if (apb_read) begin
			unique case (apb_req.paddr)
				cdb_pkg::CLK_CTRL_OFS: next_st.prdata[0] = st.clock_out_enable;
				cdb_pkg::DIVIDER_OFS:  next_st.prdata[7:0] = st.cpu_clock_divider;
				cdb_pkg::AUX_CTRL_OFS: begin
					next_st.prdata[cdb_pkg::BO_IRQ_SEL_BIT] = st.brownout_irq_select;
					next_st.prdata[cdb_pkg::BO_DISABLE_BIT] = st.brownout_disable;
				end
				cdb_pkg::PWR_STATUS_OFS: begin
					next_st.prdata[cdb_pkg::BO_FLAG_BIT]     = st.brownout_flag;
					next_st.prdata[cdb_pkg::BO_DETECT_BIT]   = st.bo_det_d;
					next_st.prdata[cdb_pkg::BO_IRQ_PEND_BIT] = st.bo_pending;
				end
				cdb_pkg::IRQ_ENABLE_OFS: begin
					next_st.prdata[cdb_pkg::GLOBAL_IRQ_EN_BIT] = st.global_irq_enable;
					next_st.prdata[cdb_pkg::BO_IRQ_EN_BIT]     = st.brownout_irq_enable;
				end
				// R1 configuration readback only
				cdb_pkg::CONFIG_OFS: begin
					next_st.prdata[2:0] = user_config_byte_one.osc_sel;
					next_st.prdata[3]   = user_config_byte_one.classic_timing_select;
					next_st.prdata[4]   = user_config_byte_one.brownout_level_select;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st                     <= '0;
			st.cpu_clock_divider   <= cdb_pkg::DIVIDER_RST;
			st.level_high          <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign apb_rsp.pready           = st.pready;
	assign apb_rsp.pslverr          = 1'b0;
	assign apb_rsp.prdata           = st.prdata;
	assign cpu_clk_en               = st.cpu_en;
	assign machine_cycle_en         = st.mc_en;
	assign clock_output_pin         = st.co_pin;
	assign second_osc_port_pin_oe   = st.pin_oe;
	assign second_osc_port_pin_out  = st.pin_out;
	assign brownout_level_high      = st.level_high;
	assign brownout_reset           = st.rst_out;
	assign brownout_irq             = st.irq_out;

endmodule

/* File: verilog/cdb_pkg.sv */
package cdb_pkg;

	// register byte addresses
	localparam logic [11:0] CLK_CTRL_OFS    = 12'h000;
	localparam logic [11:0] DIVIDER_OFS     = 12'h004;
	localparam logic [11:0] AUX_CTRL_OFS    = 12'h008;
	localparam logic [11:0] PWR_STATUS_OFS  = 12'h00c;
	localparam logic [11:0] IRQ_ENABLE_OFS  = 12'h010;
	localparam logic [11:0] CONFIG_OFS      = 12'h014;

	// field positions
	localparam int CLK_OUT_EN_BIT     = 0;
	localparam int BO_IRQ_SEL_BIT     = 5;
	localparam int BO_DISABLE_BIT     = 6;
	localparam int BO_FLAG_BIT        = 0;
	localparam int BO_DETECT_BIT      = 1;
	localparam int BO_IRQ_PEND_BIT    = 2;
	localparam int BO_IRQ_EN_BIT      = 0;
	localparam int GLOBAL_IRQ_EN_BIT  = 7;

	// reset values
	localparam logic [7:0] DIVIDER_RST    = 8'h00;
	localparam logic [7:0] AUX_CTRL_RST   = 8'h00;
	localparam logic [7:0] CLK_CTRL_RST   = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;

	// timing
	localparam int RC_OSC_KHZ      = 6000;
	localparam int REF_CLK_KHZ     = 100000;
	localparam int CLK_OUT_RATIO   = 6;
	localparam int CLASSIC_RATIO   = 2;
	localparam int BO_LOW_MV       = 2500;
	localparam int BO_HIGH_MV      = 3800;

	// oscillator source from programming-time configuration
	typedef enum logic [2:0] {
		CDB_OSC_LOW_XTAL,
		CDB_OSC_MED_XTAL,
		CDB_OSC_HIGH_XTAL,
		CDB_OSC_RC,
		CDB_OSC_EXT_CLK
	} cdb_osc_sel_e;

	typedef struct packed {
		logic [2:0] osc_sel;
		logic       classic_timing_select;
		logic       brownout_level_select;
	} cdb_cfg_s;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cdb_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} cdb_apb_rsp_s;

endpackage

/* File: verilog/cdb_ratio_div.sv */
`timescale 1ns/1ps
// glitch-free divide-by-two-times-(ratio) enable generator, ratio latched at boundary
module cdb_ratio_div #(
	parameter int W = 9
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic         tick_in,
	input  wire logic [W-1:0] half_ratio,
	output logic              tick_out
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic [W-1:0] held;
		logic         tick;
	} cdb_div_state_s;

	cdb_div_state_s st;
	cdb_div_state_s next_st;
	logic [W:0]     cnt_inc;
	logic [W:0]     period;

	// full period is twice the held ratio
	assign cnt_inc = {1'b0, st.cnt} + {{W{1'b0}}, 1'b1};
	assign period  = {st.held, 1'b0};

	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (tick_in) begin
			if (cnt_inc >= period) begin
				next_st.cnt  = '0;
				next_st.tick = 1'b1;
				// new ratio only at a period boundary
				next_st.held = half_ratio;
			end else begin
				next_st.cnt = cnt_inc[W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '{cnt: '0, held: '0, tick: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign tick_out = st.tick;

endmodule

/* File: tb/cdb_clkout_rx.sv */
`timescale 1ns/1ps
// far-side receiver: measures clock output half period in ref_clk cycles
module cdb_clkout_rx (
	input  wire logic ref_clk,
	input  wire logic pin,
	output int        half
);
	logic last;
	int   n;
	initial begin
		last = 1'b0;
		n = 0;
		half = 0;
	end
	always @(posedge ref_clk) begin
		last <= pin;
		n <= (pin !== last) ? 1 : n + 1;
		if (pin !== last)
			half <= n;
	end
endmodule

/* File: tb/cdb_clock_brownout_assertions.sv */
`timescale 1ns/1ps
module cdb_checker (
	input wire logic                  ref_clk,
	input wire logic                  rst_b,
	input wire cdb_pkg::cdb_apb_req_s apb_req,
	input wire cdb_pkg::cdb_apb_rsp_s apb_rsp,
	input wire cdb_pkg::cdb_cfg_s     user_config_byte_one,
	input wire logic                  clock_output_pin,
	input wire logic                  second_osc_port_pin_oe,
	input wire logic                  machine_cycle_en,
	input wire logic                  brownout_level_high,
	input wire logic                  brownout_reset,
	input wire logic                  brownout_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence acc_go;
		apb_req.psel && $rose(apb_req.penable);
	endsequence
	ready_resp_a: assert property (acc_go |=> apb_rsp.pready)
		else $error("no ready");
	ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("long ready");
	level_map_a: assert property ($past(rst_b, 2) |->
		brownout_level_high == !user_config_byte_one.brownout_level_select)
		else $error("level");
	xtal_out_a: assert property (user_config_byte_one.osc_sel < 3'h3 |->
		!clock_output_pin)
		else $error("clkout on xtal");
	xtal_pin_a: assert property (user_config_byte_one.osc_sel < 3'h3 |->
		!second_osc_port_pin_oe)
		else $error("pin driven");
	resp_excl_a: assert property (!(brownout_reset && brownout_irq))
		else $error("reset and irq");
	mcycle_gap_a: assert property (machine_cycle_en |=>
		!machine_cycle_en [*5])
		else $error("mcycle");
	out_low_a: assert property ($rose(clock_output_pin) |->
		!$past(clock_output_pin, 2) && !$past(clock_output_pin, 3))
		else $error("clkout");
endmodule
bind cdb_clock_brownout cdb_checker chk (.ref_clk(ref_clk), .rst_b(rst_b), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .user_config_byte_one(user_config_byte_one),
	.clock_output_pin(clock_output_pin), .second_osc_port_pin_oe(second_osc_port_pin_oe),
	.machine_cycle_en(machine_cycle_en), .brownout_level_high(brownout_level_high),
	.brownout_reset(brownout_reset), .brownout_irq(brownout_irq));

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic                  ref_clk, rst_b, blo, ppo, ppe, cen, mce, cko, poe, pout, lvh, brst, birq;
	logic                  bhi;
	logic [1:0]            pp_d;
	int                    dv[4] = '{0, 1, 3, 255};
	cdb_pkg::cdb_apb_req_s req;
	cdb_pkg::cdb_apb_rsp_s rsp;
	cdb_pkg::cdb_cfg_s     cfg;
	int                    bad_count, num_checks, hp, g;
	logic [31:0]           rs, exq[$];
	cdb_clock_brownout uut (.ref_clk(ref_clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
		.user_config_byte_one(cfg), .osc_tick(1'b1), .osc_running(1'b1), .bo_below_low(blo),
		.bo_below_high(bhi), .port_pin_out(ppo), .port_pin_oe(ppe), .cpu_clk_en(cen),
		.machine_cycle_en(mce), .clock_output_pin(cko), .second_osc_port_pin_oe(poe),
		.second_osc_port_pin_out(pout), .brownout_level_high(lvh), .brownout_reset(brst),
		.brownout_irq(birq));
	cdb_clkout_rx rx (.ref_clk(ref_clk), .pin(cko), .half(hp));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	always @(posedge ref_clk) begin
		rs <= xs(rs);
		pp_d <= {ppe, ppo};
		ppo <= rs[0];
		ppe <= rs[1];
	end
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// read: d is the expected word
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		if (!w)
			exq.push_back(d);
		@(posedge ref_clk);
		req <= '{1'b1, 1'b0, w, a, w ? d : 32'h0};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1) begin
			bad_count++;
			test_done;
		end
		req <= '0;
	endtask
	always @(posedge ref_clk)
		if (rsp.pready === 1'b1 && req.psel === 1'b1 && req.pwrite === 1'b0)
			chk(rsp.prdata, exq.pop_front());
	task wait_en;
		g = 0;
		do begin
			@(negedge ref_clk);
			g++;
		end while (cen !== 1'b1 && g < 3000);
		if (g >= 3000) begin
			bad_count++;
			test_done;
		end
	endtask
	task bo(input logic [1:0] v);
		@(posedge ref_clk);
		{bhi, blo} <= v;
		repeat (3) @(negedge ref_clk);
	endtask
	task do_reset;
		rst_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
	endtask
	initial begin
		rst_b = 1'b0;
		blo = 1'b0;
		bhi = 1'b0;
		ppo = 1'b0;
		ppe = 1'b0;
		req = '0;
		rs = 32'hc1eb7871;
		cfg = '{3'h0, 1'b0, 1'b1};
		bad_count = 0;
		num_checks = 0;
		do_reset;
		apb(1'b1, cdb_pkg::CLK_CTRL_OFS, 32'h1);
		repeat (20) @(negedge ref_clk);
		chk(cko, 1'b0);
		chk(poe, 1'b0);
		apb(1'b1, cdb_pkg::CLK_CTRL_OFS, 32'h0);
		cfg <= '{3'h4, 1'b0, 1'b1};
		@(posedge ref_clk);
		repeat (8) begin
			@(posedge ref_clk);
			chk({poe, pout}, pp_d);
		end
		$display("test crystal done");
		cfg <= '{3'h3, 1'b0, 1'b1};
		do_reset;
		apb(1'b0, cdb_pkg::CLK_CTRL_OFS, 32'h0);
		apb(1'b0, cdb_pkg::DIVIDER_OFS, 32'h0);
		apb(1'b0, cdb_pkg::AUX_CTRL_OFS, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk(lvh, 1'b0);
		foreach (dv[i]) begin
			apb(1'b1, cdb_pkg::DIVIDER_OFS, dv[i]);
			repeat (3) wait_en;
			chk(g, i == 0 ? 1 : 2 * (dv[i] + 1));
		end
		g = rs[7:0];
		apb(1'b1, cdb_pkg::DIVIDER_OFS, g);
		apb(1'b0, cdb_pkg::DIVIDER_OFS, g);
		apb(1'b1, cdb_pkg::DIVIDER_OFS, 32'h0);
		cfg <= '{3'h3, 1'b1, 1'b1};
		repeat (3) wait_en;
		chk(g, cdb_pkg::CLASSIC_RATIO);
		@(posedge ref_clk);
		cfg <= '{3'h3, 1'b0, 1'b1};
		apb(1'b1, cdb_pkg::CLK_CTRL_OFS, 32'h1);
		repeat (40) @(negedge ref_clk);
		chk(hp, 3);
		apb(1'b1, cdb_pkg::CLK_CTRL_OFS, 32'h0);
		repeat (10) @(negedge ref_clk);
		chk(cko, 1'b0);
		$display("test clock done");
		bo(2'b11);
		chk(brst, 1'b1);
		apb(1'b0, cdb_pkg::PWR_STATUS_OFS, 32'h3);
		bo(2'b00);
		chk(brst, 1'b0);
		apb(1'b1, cdb_pkg::PWR_STATUS_OFS, 32'h1);
		apb(1'b0, cdb_pkg::PWR_STATUS_OFS, 32'h0);
		bo(2'b10);
		chk(brst, 1'b0);
		apb(1'b0, cdb_pkg::PWR_STATUS_OFS, 32'h0);
		bo(2'b00);
		apb(1'b1, cdb_pkg::AUX_CTRL_OFS, 32'h20);
		apb(1'b1, cdb_pkg::IRQ_ENABLE_OFS, 32'h1);
		bo(2'b11);
		chk({brst, birq}, 2'b00);
		apb(1'b0, cdb_pkg::PWR_STATUS_OFS, 32'h7);
		apb(1'b1, cdb_pkg::IRQ_ENABLE_OFS, 32'h81);
		repeat (2) @(negedge ref_clk);
		chk(birq, 1'b1);
		apb(1'b1, cdb_pkg::PWR_STATUS_OFS, 32'h4);
		repeat (3) @(negedge ref_clk);
		chk(birq, 1'b0);
		bo(2'b00);
		apb(1'b1, cdb_pkg::PWR_STATUS_OFS, 32'h1);
		apb(1'b1, cdb_pkg::AUX_CTRL_OFS, 32'h60);
		bo(2'b11);
		chk({brst, birq}, 2'b00);
		apb(1'b0, cdb_pkg::PWR_STATUS_OFS, 32'h0);
		bo(2'b00);
		$display("test brownout done");
		test_done;
	end
endmodule
